// ===== clfs_regs.svh
// Purpose: timing figures, encodings and input positions of the fault sequencer
// Assumes: reference clock given in MHz; times kept in their own unit
// Notes:   cycle counts are derived here; only the nanosecond time needs rounding, and it rounds up
`ifndef CLFS_REGS_SVH
`define CLFS_REGS_SVH

`define CLFS_CLK_MHZ            100
`define CLFS_CYC_PER_MS         (1000 * `CLFS_CLK_MHZ)

`define CLFS_STARTUP_BLANK_MS   100
`define CLFS_OC_BLANK_MS        10
`define CLFS_RETRY_MS           1000
`define CLFS_FAST_OFF_US        1
`define CLFS_FAST_RECOVER_US    400
`define CLFS_IN_SW_ON_US        100
`define CLFS_SLOW_REV_DEB_US    10
`define CLFS_FAST_REV_NS        500

`define CLFS_STARTUP_BLANK_CYC  (`CLFS_STARTUP_BLANK_MS * `CLFS_CYC_PER_MS)
`define CLFS_OC_BLANK_CYC       (`CLFS_OC_BLANK_MS * `CLFS_CYC_PER_MS)
`define CLFS_RETRY_CYC          (`CLFS_RETRY_MS * `CLFS_CYC_PER_MS)
`define CLFS_FAST_OFF_CYC       (`CLFS_FAST_OFF_US * `CLFS_CLK_MHZ)
`define CLFS_FAST_RECOVER_CYC   (`CLFS_FAST_RECOVER_US * `CLFS_CLK_MHZ)
`define CLFS_IN_SW_ON_CYC       (`CLFS_IN_SW_ON_US * `CLFS_CLK_MHZ)
`define CLFS_SLOW_REV_DEB_CYC   (`CLFS_SLOW_REV_DEB_US * `CLFS_CLK_MHZ)
`define CLFS_FAST_REV_CYC       ((`CLFS_FAST_REV_NS * `CLFS_CLK_MHZ + 999) / 1000)

// limit_response_select decoding: 0 short, 1 resistor, 2 or 3 open
`define CLFS_SEL_CONT           2'h0
`define CLFS_SEL_LATCH          2'h1

// positions in the synchroniser vector
`define CLFS_IN_ENABLE          0
`define CLFS_IN_PWR_GOOD        1
`define CLFS_IN_OC              2
`define CLFS_IN_FAST_TRIP       3
`define CLFS_IN_AT_TARGET       4
`define CLFS_IN_OVER_TEMP       5
`define CLFS_IN_SLOW_REV        6
`define CLFS_IN_FAST_REV        7
`define CLFS_IN_SEL_LO          8
`define CLFS_IN_SEL_HI          9
`define CLFS_IN_WIDTH           10

`endif

// ===== clfs_pkg.sv
// Purpose: shared types of the fault sequencer
// Assumes: nothing beyond the timing header
// Notes:   encodings left to the tools
`default_nettype none
package clfs_pkg;
    typedef enum logic [2:0] {
        CLFS_OFF, CLFS_STARTUP, CLFS_NORMAL, CLFS_FAULT_WAIT,
        CLFS_RETRY, CLFS_FAST_TRIP, CLFS_LATCHED
    } clfs_state_t;
    typedef enum logic [1:0] {
        CLFS_REV_OK, CLFS_REV_BLOCK, CLFS_REV_RECOVER
    } clfs_rev_t;
    typedef enum logic [1:0] {
        CLFS_MODE_CONT, CLFS_MODE_LATCH, CLFS_MODE_AUTO
    } clfs_mode_t;
endpackage
`default_nettype wire

// ===== clfs_tmr_if.sv
// Purpose: run/done pair between the sequencer and one delay counter
// Assumes: single clock domain
// Notes:   run is a level, done a one-cycle pulse
`default_nettype none
interface clfs_tmr_if;
    logic run;
    logic done;
    modport ctrl (output run, input done);
    modport tmr  (input run, output done);
endinterface
`default_nettype wire

// ===== clfs_timer.sv
// Purpose: delay counter that fires after LEN consecutive cycles of run
// Assumes: LEN of at least one cycle
// Notes:   dropping run clears the count; after firing it restarts from zero
`default_nettype none
module clfs_timer #(
    parameter int unsigned LEN = 1
) (
    input  wire logic clk_sys,
    input  wire logic resetn,
    clfs_tmr_if.tmr   tif
);
    localparam int unsigned W = $clog2(LEN + 1);

    if (LEN < 1) begin : g_bad_len
        $error("clfs_timer: LEN must be at least one");
    end

    logic [W-1:0] cnt_ff;

    assign tif.done = (cnt_ff == W'(LEN));

    // cleared on a dropped run so a short event never accumulates
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt_ff <= '0;
        end else if (!tif.run || tif.done) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + W'(1);
        end
    end
endmodule
`default_nettype wire

// ===== clfs_sequencer.sv
// Purpose: overcurrent, thermal, fast-trip and reverse fault sequencing
// Assumes: comparator and pin inputs are asynchronous and pass two flip-flops
// Notes:   fault pins are open-drain: out held low, oe high while asserting
`default_nettype none
`include "clfs_regs.svh"

module clfs_sequencer
    import clfs_pkg::*;
#(
    parameter int unsigned STARTUP_BLANK_CYC = `CLFS_STARTUP_BLANK_CYC,
    parameter int unsigned OC_BLANK_CYC      = `CLFS_OC_BLANK_CYC,
    parameter int unsigned RETRY_CYC         = `CLFS_RETRY_CYC,
    parameter int unsigned FAST_RECOVER_CYC  = `CLFS_FAST_RECOVER_CYC,
    parameter int unsigned IN_SW_ON_CYC      = `CLFS_IN_SW_ON_CYC,
    parameter int unsigned SLOW_REV_DEB_CYC  = `CLFS_SLOW_REV_DEB_CYC,
    parameter int unsigned FAST_REV_CYC      = `CLFS_FAST_REV_CYC,
    parameter bit          REV_BLOCK_EN      = 1'b1
) (
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       enable,
    input  wire logic       power_good,
    input  wire logic [1:0] limit_response_select,
    input  wire logic       overcurrent,
    input  wire logic       fast_trip,
    input  wire logic       output_at_target,
    input  wire logic       over_temperature,
    input  wire logic       slow_reverse,
    input  wire logic       fast_reverse,
    output logic            output_switch_on,
    output logic            input_switch_on,
    output logic            forward_fault_out_n,
    output logic            forward_fault_oe,
    output logic            reverse_fault_out_n,
    output logic            reverse_fault_oe
);
    localparam int FAST_OFF_MAX = `CLFS_FAST_OFF_CYC;

    if (FAST_OFF_MAX < 3 || STARTUP_BLANK_CYC < 1 || RETRY_CYC < 1) begin : g_bad_cfg
        $error("clfs_sequencer: delay counts cannot be served");
    end

    // ---------------- input synchroniser
    logic [`CLFS_IN_WIDTH-1:0] sync1_ff;
    logic [`CLFS_IN_WIDTH-1:0] sync2_ff;
    logic [`CLFS_IN_WIDTH-1:0] raw_in;

    assign raw_in = {limit_response_select, fast_reverse, slow_reverse, over_temperature,
                     output_at_target, fast_trip, overcurrent, power_good, enable};

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= raw_in;
            sync2_ff <= sync1_ff;
        end
    end

    logic       en_ok;
    logic       oc_s;
    logic       fast_s;
    logic       tgt_s;
    logic       ot_s;
    logic       slow_rev_s;
    logic       fast_rev_s;
    logic [1:0] sel_s;
    clfs_mode_t mode;

    assign en_ok      = sync2_ff[`CLFS_IN_ENABLE] && sync2_ff[`CLFS_IN_PWR_GOOD];
    assign oc_s       = sync2_ff[`CLFS_IN_OC];
    assign fast_s     = sync2_ff[`CLFS_IN_FAST_TRIP];
    assign tgt_s      = sync2_ff[`CLFS_IN_AT_TARGET];
    assign ot_s       = sync2_ff[`CLFS_IN_OVER_TEMP];
    assign slow_rev_s = sync2_ff[`CLFS_IN_SLOW_REV];
    assign fast_rev_s = sync2_ff[`CLFS_IN_FAST_REV];
    assign sel_s      = sync2_ff[`CLFS_IN_SEL_HI:`CLFS_IN_SEL_LO];

    always_comb begin
        case (sel_s)
            `CLFS_SEL_CONT:  mode = CLFS_MODE_CONT;
            `CLFS_SEL_LATCH: mode = CLFS_MODE_LATCH;
            default:         mode = CLFS_MODE_AUTO;
        endcase
    end

    // ---------------- delay counters
    clfs_state_t state_ff;
    clfs_state_t nxt_state;
    clfs_rev_t   rev_ff;
    clfs_rev_t   nxt_rev;

    clfs_tmr_if t_start ();
    clfs_tmr_if t_oc ();
    clfs_tmr_if t_retry ();
    clfs_tmr_if t_ftrip ();
    clfs_tmr_if t_srev ();
    clfs_tmr_if t_frev ();
    clfs_tmr_if t_inon ();

    assign t_start.run = (state_ff == CLFS_STARTUP) && !tgt_s;
    assign t_oc.run    = (state_ff == CLFS_NORMAL) && oc_s;
    assign t_retry.run = (state_ff == CLFS_RETRY);
    assign t_ftrip.run = (state_ff == CLFS_FAST_TRIP);
    assign t_srev.run  = slow_rev_s;
    assign t_frev.run  = fast_rev_s;
    assign t_inon.run  = (rev_ff == CLFS_REV_RECOVER);

    clfs_timer #(.LEN(STARTUP_BLANK_CYC)) u_t_start (
        .clk_sys (clk_sys), .resetn (resetn), .tif (t_start));
    clfs_timer #(.LEN(OC_BLANK_CYC)) u_t_oc (
        .clk_sys (clk_sys), .resetn (resetn), .tif (t_oc));
    clfs_timer #(.LEN(RETRY_CYC)) u_t_retry (
        .clk_sys (clk_sys), .resetn (resetn), .tif (t_retry));
    clfs_timer #(.LEN(FAST_RECOVER_CYC)) u_t_ftrip (
        .clk_sys (clk_sys), .resetn (resetn), .tif (t_ftrip));
    clfs_timer #(.LEN(SLOW_REV_DEB_CYC)) u_t_srev (
        .clk_sys (clk_sys), .resetn (resetn), .tif (t_srev));
    clfs_timer #(.LEN(FAST_REV_CYC)) u_t_frev (
        .clk_sys (clk_sys), .resetn (resetn), .tif (t_frev));
    clfs_timer #(.LEN(IN_SW_ON_CYC)) u_t_inon (
        .clk_sys (clk_sys), .resetn (resetn), .tif (t_inon));

    // ---------------- forward sequencing
    logic ret_normal_ff;

    always_comb begin
        nxt_state = state_ff;
        if (!en_ok) begin
            nxt_state = CLFS_OFF;
        end else begin
            case (state_ff)
                CLFS_OFF: begin
                    nxt_state = CLFS_STARTUP;
                end
                CLFS_STARTUP: begin
                    if (fast_s) begin
                        nxt_state = CLFS_FAST_TRIP;
                    end else if (tgt_s) begin
                        nxt_state = CLFS_NORMAL;
                    end else if (t_start.done) begin
                        case (mode)
                            CLFS_MODE_CONT:  nxt_state = CLFS_NORMAL;
                            CLFS_MODE_LATCH: nxt_state = CLFS_LATCHED;
                            default:         nxt_state = CLFS_FAULT_WAIT;
                        endcase
                    end
                end
                CLFS_NORMAL: begin
                    if (fast_s) begin
                        nxt_state = CLFS_FAST_TRIP;
                    end else if (t_oc.done || ot_s) begin
                        case (mode)
                            CLFS_MODE_LATCH: nxt_state = CLFS_LATCHED;
                            CLFS_MODE_AUTO:  nxt_state = CLFS_FAULT_WAIT;
                            default:         nxt_state = CLFS_NORMAL;
                        endcase
                    end
                end
                CLFS_FAULT_WAIT: begin
                    if (!ot_s) begin
                        nxt_state = CLFS_RETRY;
                    end
                end
                CLFS_RETRY: begin
                    if (t_retry.done) begin
                        nxt_state = CLFS_STARTUP;
                    end
                end
                CLFS_FAST_TRIP: begin
                    if (t_ftrip.done) begin
                        nxt_state = ret_normal_ff ? CLFS_NORMAL : CLFS_STARTUP;
                    end
                end
                CLFS_LATCHED: begin
                    nxt_state = CLFS_LATCHED;
                end
                default: begin
                    nxt_state = CLFS_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_ff <= CLFS_OFF;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // where a fast trip returns to; startup restarts its blanking from zero
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ret_normal_ff <= 1'h0;
        end else if (nxt_state == CLFS_FAST_TRIP && state_ff != CLFS_FAST_TRIP) begin
            ret_normal_ff <= (state_ff == CLFS_NORMAL);
        end
    end

    // thermal shutdown forces the switch off in every conducting state
    logic nxt_out_on;
    assign nxt_out_on = en_ok && !ot_s &&
                        (nxt_state == CLFS_STARTUP || nxt_state == CLFS_NORMAL);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            output_switch_on <= 1'h0;
        end else begin
            output_switch_on <= nxt_out_on;
        end
    end

    // set wins over release so an event in the release cycle is kept
    logic fwd_set;
    logic fwd_clr;
    assign fwd_set = en_ok && (nxt_state == CLFS_FAULT_WAIT || nxt_state == CLFS_LATCHED ||
                     (state_ff == CLFS_STARTUP && t_start.done) ||
                     (state_ff == CLFS_NORMAL && t_oc.done) ||
                     (ot_s && state_ff != CLFS_OFF));
    assign fwd_clr = !en_ok || (tgt_s && !oc_s && !ot_s &&
                     (state_ff == CLFS_STARTUP || state_ff == CLFS_NORMAL));

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            forward_fault_oe <= 1'h0;
        end else if (fwd_set) begin
            forward_fault_oe <= 1'h1;
        end else if (fwd_clr) begin
            forward_fault_oe <= 1'h0;
        end
    end

    // ---------------- reverse blocking
    logic rev_hit;
    assign rev_hit = REV_BLOCK_EN && (t_srev.done || t_frev.done);

    always_comb begin
        nxt_rev = rev_ff;
        case (rev_ff)
            CLFS_REV_OK: begin
                if (rev_hit) begin
                    nxt_rev = CLFS_REV_BLOCK;
                end
            end
            CLFS_REV_BLOCK: begin
                if (!slow_rev_s && !fast_rev_s) begin
                    nxt_rev = CLFS_REV_RECOVER;
                end
            end
            CLFS_REV_RECOVER: begin
                if (rev_hit) begin
                    nxt_rev = CLFS_REV_BLOCK;
                end else if (t_inon.done) begin
                    nxt_rev = CLFS_REV_OK;
                end
            end
            default: begin
                nxt_rev = CLFS_REV_OK;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rev_ff <= CLFS_REV_OK;
        end else begin
            rev_ff <= nxt_rev;
        end
    end

    // flag released only once the input switch has had its turn-on time
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            input_switch_on     <= 1'h0;
            reverse_fault_oe    <= 1'h0;
            forward_fault_out_n <= 1'h0;
            reverse_fault_out_n <= 1'h0;
        end else begin
            input_switch_on     <= en_ok && (nxt_rev != CLFS_REV_BLOCK);
            reverse_fault_oe    <= (nxt_rev != CLFS_REV_OK);
            forward_fault_out_n <= 1'h0;
            reverse_fault_out_n <= 1'h0;
        end
    end

    // ---------------- checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence seq_rev_detect;
        rev_ff == CLFS_REV_OK && REV_BLOCK_EN && (t_srev.done || t_frev.done);
    endsequence
    sequence seq_rev_blocked;
        !input_switch_on && reverse_fault_oe;
    endsequence

    fast_trip_off_a: assert property (
        (state_ff == CLFS_STARTUP || state_ff == CLFS_NORMAL) && fast_s && en_ok
        |=> !output_switch_on [*2])
        else $error("output switch still on after fast trip");
    latch_hold_a: assert property (
        state_ff == CLFS_LATCHED && en_ok |=> state_ff == CLFS_LATCHED && !output_switch_on)
        else $error("latched state left without enable or power cycle");
    retry_off_a: assert property (
        state_ff == CLFS_RETRY |-> !output_switch_on)
        else $error("output switch on during retry delay");
    retry_restart_a: assert property (
        state_ff == CLFS_RETRY && t_retry.done && en_ok |=> state_ff == CLFS_STARTUP)
        else $error("startup not restarted after retry delay");
    retry_tsd_wait_a: assert property (
        state_ff == CLFS_FAULT_WAIT && ot_s && en_ok |=> state_ff == CLFS_FAULT_WAIT)
        else $error("retry started during thermal shutdown");
    retry_flag_a: assert property (
        state_ff == CLFS_RETRY && en_ok |=> forward_fault_oe)
        else $error("fault flag released during autoretry");
    cont_keep_on_a: assert property (
        mode == CLFS_MODE_CONT && state_ff == CLFS_NORMAL && t_oc.done && en_ok
        && !ot_s && !fast_s |=> forward_fault_oe && output_switch_on)
        else $error("continuous expiry must flag and keep switch on");
    auto_start_off_a: assert property (
        mode == CLFS_MODE_AUTO && state_ff == CLFS_STARTUP && t_start.done && en_ok
        && !tgt_s && !fast_s |=> state_ff == CLFS_FAULT_WAIT ##1 !output_switch_on)
        else $error("autoretry startup expiry did not switch off");
    target_early_a: assert property (
        state_ff == CLFS_STARTUP && tgt_s && en_ok && !fast_s |=> state_ff == CLFS_NORMAL)
        else $error("target reached but startup not left");
    rev_block_a: assert property (
        seq_rev_detect |=> seq_rev_blocked)
        else $error("reverse detection did not block input switch");
    rev_off_a: assert property (
        !REV_BLOCK_EN |-> !reverse_fault_oe)
        else $error("reverse flag raised with blocking disabled");
endmodule
`default_nettype wire

// ===== clfs_far_side.sv
// Purpose: behavioural far side: load and output voltage, fault-pin pull-ups
// Assumes: output reaches its target a few cycles after the switch closes
// Notes:   short_cmd holds the output below target, as a hard load would
`default_nettype none
module clfs_far_side (
    input  wire logic clk_sys,
    input  wire logic short_cmd,
    input  wire logic output_switch_on,
    input  wire logic forward_fault_out_n,
    input  wire logic forward_fault_oe,
    input  wire logic reverse_fault_out_n,
    input  wire logic reverse_fault_oe,
    output logic      output_at_target,
    output wire logic fwd_pin,
    output wire logic rev_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    int charge_cnt = 0;
    // pins have external pull-ups, so a released pin reads high
    assign fwd_pin = forward_fault_oe ? forward_fault_out_n : 1'b1;
    assign rev_pin = reverse_fault_oe ? reverse_fault_out_n : 1'b1;
    initial output_at_target = 1'b0;
    always @(posedge clk_sys) begin
        if (!output_switch_on || short_cmd) begin
            charge_cnt <= 0;
        end else if (charge_cnt < 3) begin
            charge_cnt <= charge_cnt + 1;
        end
    end
    always @(negedge clk_sys) begin
        output_at_target <= (charge_cnt >= 3);
    end
endmodule
`default_nettype wire

// ===== current_limit_fault_sequencer_test.sv
// Purpose: self-checking bench for the fault sequencer
// Assumes: shortened delay parameters; inputs driven on the falling edge
// Notes:   windows allow for the two-flop input synchroniser
`default_nettype none
module current_limit_fault_sequencer_test;
    import clfs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SB = 20, OB = 10, RT = 30, FR = 15, SW = 8;
    logic clk_sys = 1'b0, resetn = 1'b0, enable = 1'b0, power_good = 1'b1;
    logic [1:0] limit_response_select = 2'h2;
    logic overcurrent = 1'b0, fast_trip = 1'b0, over_temperature = 1'b0;
    logic slow_reverse = 1'b0, fast_reverse = 1'b0, short_cmd = 1'b1;
    logic output_at_target, output_switch_on, input_switch_on;
    logic forward_fault_out_n, forward_fault_oe, reverse_fault_out_n, reverse_fault_oe;
    wire logic fwd_pin, rev_pin;
    logic nr_in_on, nr_rev_oe;
    int fail_count = 0, n_checks = 0, n;

    always #5 clk_sys = ~clk_sys;

    clfs_sequencer #(.STARTUP_BLANK_CYC(SB), .OC_BLANK_CYC(OB), .RETRY_CYC(RT),
        .FAST_RECOVER_CYC(FR), .IN_SW_ON_CYC(SW), .SLOW_REV_DEB_CYC(5),
        .FAST_REV_CYC(2), .REV_BLOCK_EN(1'b1)) uut (
        .clk_sys(clk_sys), .resetn(resetn), .enable(enable), .power_good(power_good),
        .limit_response_select(limit_response_select), .overcurrent(overcurrent),
        .fast_trip(fast_trip), .output_at_target(output_at_target),
        .over_temperature(over_temperature), .slow_reverse(slow_reverse),
        .fast_reverse(fast_reverse), .output_switch_on(output_switch_on),
        .input_switch_on(input_switch_on), .forward_fault_out_n(forward_fault_out_n),
        .forward_fault_oe(forward_fault_oe), .reverse_fault_out_n(reverse_fault_out_n),
        .reverse_fault_oe(reverse_fault_oe));

    clfs_far_side far (
        .clk_sys(clk_sys), .short_cmd(short_cmd), .output_switch_on(output_switch_on),
        .forward_fault_out_n(forward_fault_out_n), .forward_fault_oe(forward_fault_oe),
        .reverse_fault_out_n(reverse_fault_out_n), .reverse_fault_oe(reverse_fault_oe),
        .output_at_target(output_at_target), .fwd_pin(fwd_pin), .rev_pin(rev_pin));

    // same stimulus with reverse blocking built out: reverse must change nothing
    clfs_sequencer #(.STARTUP_BLANK_CYC(SB), .OC_BLANK_CYC(OB), .RETRY_CYC(RT),
        .FAST_RECOVER_CYC(FR), .IN_SW_ON_CYC(SW), .SLOW_REV_DEB_CYC(5),
        .FAST_REV_CYC(2), .REV_BLOCK_EN(1'b0)) uut_norev (
        .clk_sys(clk_sys), .resetn(resetn), .enable(enable), .power_good(power_good),
        .limit_response_select(limit_response_select), .overcurrent(overcurrent),
        .fast_trip(fast_trip), .output_at_target(output_at_target),
        .over_temperature(over_temperature), .slow_reverse(slow_reverse),
        .fast_reverse(fast_reverse), .output_switch_on(),
        .input_switch_on(nr_in_on), .forward_fault_out_n(),
        .forward_fault_oe(), .reverse_fault_out_n(),
        .reverse_fault_oe(nr_rev_oe));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t ns: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    function automatic logic sig(input int sel);
        case (sel)
            0:       return output_switch_on;
            1:       return input_switch_on;
            2:       return fwd_pin;
            default: return rev_pin;
        endcase
    endfunction

    // counts falling edges until the chosen output shows val, giving up at lim
    task automatic wait_sig(input int sel, input logic val, input int lim);
        n = 0;
        while (sig(sel) !== val && n < lim) begin
            @(negedge clk_sys);
            n++;
        end
        // a wait that runs out is a failure even where no check follows
        if (sig(sel) !== val) begin
            fail_count++;
            $display("mismatch at %0t ns: seen %0h expected %0h", $time, sig(sel), val);
        end
    endtask

    task automatic idle(input int cyc);
        repeat (cyc) @(negedge clk_sys);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic auto_startup_retry();
        enable = 1'b1;
        wait_sig(0, 1'b1, 10);
        wait_sig(0, 1'b0, SB + 10);
        check(n inside {[SB - 3 : SB + 4]}, 1'b1);
        check(fwd_pin, 1'b0);
        wait_sig(0, 1'b1, RT + 20);
        check(n inside {[RT - 1 : RT + 5]}, 1'b1);
        check(fwd_pin, 1'b0);
        short_cmd = 1'b0;
        wait_sig(2, 1'b1, 20);
        check(n < 20, 1'b1);
        idle(SB + 10);
        check(output_switch_on, 1'b1);
    endtask

    task automatic normal_overcurrent();
        overcurrent = 1'b1;
        idle(OB - 4);
        overcurrent = 1'b0;
        idle(OB + 10);
        check({output_switch_on, fwd_pin}, 2'h3);
        limit_response_select = 2'h0;
        overcurrent = 1'b1;
        wait_sig(2, 1'b0, OB + 10);
        check(output_switch_on, 1'b1);
        overcurrent = 1'b0;
        wait_sig(2, 1'b1, 10);
        check(n < 10, 1'b1);
        limit_response_select = 2'h1;
        idle(4);
        overcurrent = 1'b1;
        wait_sig(0, 1'b0, OB + 10);
        check(n inside {[OB - 2 : OB + 5]}, 1'b1);
        check(fwd_pin, 1'b0);
        overcurrent = 1'b0;
        idle(RT + 20);
        check(output_switch_on, 1'b0);
        enable = 1'b0;
        idle(5);
        enable = 1'b1;
        wait_sig(0, 1'b1, 10);
        check(n < 10, 1'b1);
        limit_response_select = 2'h2;
        wait_sig(2, 1'b1, 20);
    endtask

    task automatic thermal_and_fast_trip();
        idle(SB);
        over_temperature = 1'b1;
        wait_sig(0, 1'b0, 10);
        check({n < 10, fwd_pin}, 2'h2);
        idle(RT + 20);
        check(output_switch_on, 1'b0);
        over_temperature = 1'b0;
        wait_sig(0, 1'b1, RT + 20);
        check(n inside {[RT - 1 : RT + 6]}, 1'b1);
        wait_sig(2, 1'b1, 20);
        idle(SB + 5);
        fast_trip = 1'b1;
        idle(3);
        fast_trip = 1'b0;
        check({output_switch_on, input_switch_on}, 2'h1);
        wait_sig(0, 1'b1, FR + 10);
        check(n inside {[FR - 5 : FR + 3]}, 1'b1);
    endtask

    task automatic reverse_blocking();
        idle(SB + 5);
        slow_reverse = 1'b1;
        wait_sig(1, 1'b0, 20);
        check({n < 20, rev_pin, output_switch_on}, 3'h5);
        check({nr_in_on, nr_rev_oe}, 2'h2);
        slow_reverse = 1'b0;
        wait_sig(1, 1'b1, 10);
        check(n < 10, 1'b1);
        wait_sig(3, 1'b1, SW + 8);
        check(n inside {[SW - 3 : SW + 3]}, 1'b1);
        fast_reverse = 1'b1;
        idle(4);
        fast_reverse = 1'b0;
        // the block lands one edge after the response count ends
        idle(1);
        check({input_switch_on, rev_pin, output_switch_on}, 3'h1);
        check({nr_in_on, nr_rev_oe}, 2'h2);
        wait_sig(3, 1'b1, SW + 15);
        check(input_switch_on, 1'b1);
    endtask

    task automatic latch_startup();
        limit_response_select = 2'h1;
        short_cmd = 1'b1;
        enable = 1'b0;
        idle(5);
        enable = 1'b1;
        wait_sig(0, 1'b1, 10);
        wait_sig(0, 1'b0, SB + 10);
        check({(n inside {[SB - 3 : SB + 4]}), fwd_pin}, 2'h2);
        idle(RT + 20);
        check({output_switch_on, fwd_pin}, 2'h0);
        // recovery by cycling input power rather than enable
        short_cmd = 1'b0;
        power_good = 1'b0;
        idle(5);
        power_good = 1'b1;
        wait_sig(0, 1'b1, 10);
        check({(n < 10), fwd_pin}, 2'h3);
        idle(SB + 5);
        check({output_switch_on, fwd_pin}, 2'h3);
    endtask

    initial begin
        idle(20);
        resetn = 1'b1;
        idle(2);
        auto_startup_retry();
        normal_overcurrent();
        thermal_and_fast_trip();
        reverse_blocking();
        latch_startup();
        test_done();
    end

    // the whole sequence needs well under 2000 cycles
    initial begin
        #50us;
        fail_count++;
        test_done();
    end
endmodule
`default_nettype wire
